// [rtl/crs_core_regs.sv]
// top of the cpu core register set: accumulator, index pair, pointer, condition flags
// assumes decoder, alu and interrupt sequencer on the same clock drive the core-side pulses
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "crs_map.svh"

module crs_core_regs (
  // clock and reset
  input logic clk_i,
  input logic reset_i,
  // register port
  input logic [2:0] addr_i,
  input logic [7:0] wdata_i,
  input logic wr_i,
  input logic rd_i,
  output logic [7:0] rdata_o,
  // instruction execution
  input logic instr_end_i,
  input logic prefix_i,
  input logic acc_we_i,
  input logic [7:0] acc_wdata_i,
  input logic idx_we_i,
  input logic [7:0] idx_wdata_i,
  input logic [7:0] flag_mask_i,
  input logic [7:0] flag_val_i,
  // pointer sequencing
  input logic pc_inc_i,
  input logic pc_load_i,
  input logic [15:0] pc_target_i,
  // stacking port
  input logic stk_rd_i,
  input logic stk_we_i,
  input crs_pkg::crs_stk_t stk_sel_i,
  input logic [7:0] stk_data_i,
  output logic [7:0] stk_byte_o,
  // register contents
  output logic [7:0] acc_o,
  output logic [7:0] x_o,
  output logic [7:0] y_o,
  output logic [7:0] idx_sel_o,
  output logic prefix_o,
  output logic [15:0] pc_o,
  output logic [7:0] cc_o
);

  logic [7:0] acc_r;
  logic [7:0] cc_r;
  logic [7:0] rdata_r;
  logic [7:0] stk_byte_r;

  // ****************************************
  // shared functions
  // ****************************************
  // merge new bits under a mask; the two top flag bits always read zero
  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = ((old_v & ~mask) | (new_v & mask)) & `CRS_CC_USED;
  endfunction

  // one byte view for both the register port and the stacking port
  function automatic logic [7:0] pick(input logic [2:0] a);
    case (a)
      `CRS_A_ACC: pick = acc_r;
      `CRS_A_IDX1: pick = x_o;
      `CRS_A_IDX2: pick = y_o;
      `CRS_A_PTRLO: pick = pc_o[7:0];
      `CRS_A_PTRHI: pick = pc_o[15:8];
      `CRS_A_CC: pick = cc_r;
      `CRS_A_STAT: pick = {7'h00, prefix_o};
      default: pick = `CRS_RST_BYTE;
    endcase
  endfunction

  // ****************************************
  // write decode
  // ****************************************
  wire bus_wr_acc = wr_i && (addr_i == `CRS_A_ACC);
  wire bus_wr_x = wr_i && (addr_i == `CRS_A_IDX1);
  wire bus_wr_y = wr_i && (addr_i == `CRS_A_IDX2);
  wire bus_wr_ptrlo = wr_i && (addr_i == `CRS_A_PTRLO);
  wire bus_wr_ptrhi = wr_i && (addr_i == `CRS_A_PTRHI);
  wire bus_wr_cc = wr_i && (addr_i == `CRS_A_CC);

  wire stk_wr_acc = stk_we_i && (stk_sel_i == crs_pkg::crs_stk_acc);
  wire stk_wr_x = stk_we_i && (stk_sel_i == crs_pkg::crs_stk_idx);
  wire stk_wr_ptrlo = stk_we_i && (stk_sel_i == crs_pkg::crs_stk_ptrlo);
  wire stk_wr_ptrhi = stk_we_i && (stk_sel_i == crs_pkg::crs_stk_ptrhi);
  wire stk_wr_cc = stk_we_i && (stk_sel_i == crs_pkg::crs_stk_cc);

  // stacking select mapped onto the port address space
  wire [2:0] stk_addr = (stk_sel_i == crs_pkg::crs_stk_ptrlo) ? `CRS_A_PTRLO :
                        (stk_sel_i == crs_pkg::crs_stk_ptrhi) ? `CRS_A_PTRHI :
                        (stk_sel_i == crs_pkg::crs_stk_acc) ? `CRS_A_ACC :
                        (stk_sel_i == crs_pkg::crs_stk_idx) ? `CRS_A_IDX1 : `CRS_A_CC;

  // ****************************************
  // accumulator and condition flags
  // ****************************************
  // single accumulator
  // instruction result lands at its end
  wire ins_wr_acc = instr_end_i && acc_we_i;
  wire [7:0] acc_nxt = stk_wr_acc ? stk_data_i : ins_wr_acc ? acc_wdata_i :
                       bus_wr_acc ? wdata_i : acc_r;

  // flags pop whole or change bitwise
  wire [7:0] cc_nxt = stk_wr_cc ? merge(cc_r, stk_data_i, `CRS_ALL8) :
                      instr_end_i ? merge(cc_r, flag_val_i, flag_mask_i) :
                      bus_wr_cc ? merge(cc_r, wdata_i, `CRS_ALL8) : cc_r;

  // read data stand for one cycle only; stacked byte holds for the sequencer
  wire [7:0] rdata_nxt = rd_i ? pick(addr_i) : `CRS_RST_BYTE;
  wire [7:0] stk_byte_nxt = stk_rd_i ? pick(stk_addr) : stk_byte_r;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      acc_r <= `CRS_RST_ACC;
      cc_r <= `CRS_RST_CC;
      rdata_r <= `CRS_RST_BYTE;
      stk_byte_r <= `CRS_RST_BYTE;
    end else begin
      acc_r <= acc_nxt;
      cc_r <= cc_nxt;
      rdata_r <= rdata_nxt;
      stk_byte_r <= stk_byte_nxt;
    end
  end

  // ****************************************
  // index pair and pointer
  // ****************************************
  // index pair
  crs_index_pair u_idx (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .prefix_i(prefix_i),
    .instr_end_i(instr_end_i),
    .idx_we_i(idx_we_i),
    .idx_wdata_i(idx_wdata_i),
    .x_restore_i(stk_wr_x),
    .restore_data_i(stk_data_i),
    .bus_x_we_i(bus_wr_x),
    .bus_y_we_i(bus_wr_y),
    .bus_wdata_i(wdata_i),
    .x_o(x_o),
    .y_o(y_o),
    .sel_o(idx_sel_o),
    .prefix_o(prefix_o)
  );

  wire pc_low_we = stk_wr_ptrlo || bus_wr_ptrlo;
  wire pc_high_we = stk_wr_ptrhi || bus_wr_ptrhi;
  // stacking wins the byte lane over the port when both write a half
  wire [7:0] pc_byte = (stk_wr_ptrlo || stk_wr_ptrhi) ? stk_data_i : wdata_i;

  crs_pointer u_pc (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(pc_load_i),
    .target_i(pc_target_i),
    .inc_i(pc_inc_i),
    .low_we_i(pc_low_we),
    .high_we_i(pc_high_we),
    .byte_i(pc_byte),
    .pc_o(pc_o)
  );

  assign acc_o = acc_r;
  assign cc_o = cc_r;
  assign rdata_o = rdata_r;
  assign stk_byte_o = stk_byte_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chk_acc_hold: assert property (
    !stk_wr_acc && !ins_wr_acc && !bus_wr_acc |=> $stable(acc_o))
    else $error("accumulator changed without a write");

  chk_acc_at_end: assert property (
    ins_wr_acc && !stk_wr_acc |=> acc_o == $past(acc_wdata_i))
    else $error("accumulator missed instruction result");

  chk_acc_early: assert property (
    acc_we_i && !instr_end_i && !stk_we_i && !wr_i |=> $stable(acc_o))
    else $error("accumulator written before instruction end");

  chk_idx_pick: assert property (
    idx_sel_o == (prefix_o ? y_o : x_o))
    else $error("index select disagrees with prefix state");

  chk_prefix_span: assert property (
    prefix_i |=> prefix_o)
    else $error("prefix did not steer the next instruction");

  // a fresh prefix on the closing edge keeps the steering alive
  chk_prefix_drop: assert property (
    prefix_o && instr_end_i && !prefix_i |=> !prefix_o)
    else $error("prefix outlived its instruction");

  chk_prefix_y_write: assert property (
    prefix_o && instr_end_i && idx_we_i && !stk_wr_x && !bus_wr_x
    |=> y_o == $past(idx_wdata_i) && $stable(x_o))
    else $error("prefixed write did not land in second index");

  chk_x_unprefixed: assert property (
    !prefix_o && instr_end_i && idx_we_i && !stk_wr_x && !bus_wr_y
    |=> x_o == $past(idx_wdata_i) && $stable(y_o))
    else $error("plain write did not land in first index");

  chk_x_bus_write: assert property (
    bus_wr_x && !stk_wr_x && !(instr_end_i && idx_we_i && !prefix_o)
    |=> x_o == $past(wdata_i))
    else $error("port write missed first index");

  chk_y_bus_write: assert property (
    bus_wr_y && !(instr_end_i && idx_we_i && prefix_o) |=> y_o == $past(wdata_i))
    else $error("port write missed second index");

  chk_x_pop: assert property (
    stk_wr_x |=> x_o == $past(stk_data_i))
    else $error("first index pop mismatch");

  chk_y_irq_safe: assert property (
    stk_we_i && !(instr_end_i && idx_we_i) && !bus_wr_y |=> $stable(y_o))
    else $error("stacking touched the second index");

  chk_y_push_none: assert property (
    stk_rd_i && (stk_sel_i == crs_pkg::crs_stk_idx) |=> stk_byte_o == $past(x_o))
    else $error("stacking read the wrong index");

  chk_pc_step: assert property (
    pc_inc_i && !pc_load_i && !pc_low_we && !pc_high_we
    |=> pc_o == $past(pc_o) + `CRS_PC_STEP)
    else $error("pointer did not advance by one");

  chk_pc_hold: assert property (
    !pc_load_i && !pc_inc_i && !pc_low_we && !pc_high_we |=> $stable(pc_o))
    else $error("pointer moved without a request");

  chk_pc_jump: assert property (
    pc_load_i ##1 !pc_load_i && !pc_inc_i && !pc_low_we && !pc_high_we
    |=> pc_o == $past(pc_target_i, 2))
    else $error("pointer lost its jump target");

  // a port write to the other half shares the byte lane, so it is left out
  chk_pc_high_only: assert property (
    stk_wr_ptrhi && !pc_load_i && !bus_wr_ptrlo
    |=> pc_o[15:8] == $past(stk_data_i) && pc_o[7:0] == $past(pc_o[7:0]))
    else $error("high half write disturbed low half");

  chk_pc_low_only: assert property (
    stk_wr_ptrlo && !pc_load_i && !bus_wr_ptrhi
    |=> pc_o[7:0] == $past(stk_data_i) && pc_o[15:8] == $past(pc_o[15:8]))
    else $error("low half write disturbed high half");

  chk_pc_low_push: assert property (
    stk_rd_i && (stk_sel_i == crs_pkg::crs_stk_ptrlo) |=> stk_byte_o == $past(pc_o[7:0]))
    else $error("stacked low byte wrong");

  chk_pc_high_push: assert property (
    stk_rd_i && (stk_sel_i == crs_pkg::crs_stk_ptrhi) |=> stk_byte_o == $past(pc_o[15:8]))
    else $error("stacked high byte wrong");

  chk_stk_byte_hold: assert property (
    !stk_rd_i |=> $stable(stk_byte_o))
    else $error("stacked byte changed without a strobe");

  chk_cc_bitwise: assert property (
    instr_end_i && !stk_wr_cc
    |=> (cc_o & ~$past(flag_mask_i)) == ($past(cc_o) & ~$past(flag_mask_i)))
    else $error("unmasked flag changed");

  chk_cc_no_change: assert property (
    !instr_end_i && !stk_wr_cc && !bus_wr_cc |=> $stable(cc_o))
    else $error("flags changed without a write");

  chk_cc_pop: assert property (
    stk_wr_cc |=> cc_o == ($past(stk_data_i) & `CRS_CC_USED))
    else $error("flags pop mismatch");

  chk_cc_top_zero: assert property (
    (cc_o & ~`CRS_CC_USED) == `CRS_RST_BYTE)
    else $error("unused flag bits set");

  chk_acc_bus_write: assert property (
    bus_wr_acc && !stk_wr_acc && !ins_wr_acc |=> acc_o == $past(wdata_i))
    else $error("port write missed accumulator");

  chk_acc_pop: assert property (
    stk_wr_acc |=> acc_o == $past(stk_data_i))
    else $error("accumulator pop mismatch");

  chk_read_once: assert property (
    rd_i ##1 !rd_i |=> rdata_o == `CRS_RST_BYTE)
    else $error("read data held past its cycle");

  chk_read_acc: assert property (
    rd_i && (addr_i == `CRS_A_ACC) |=> rdata_o == $past(acc_o))
    else $error("port read of accumulator wrong");

  chk_reset_state: assert property (
    $past(reset_i) |-> acc_o == `CRS_RST_ACC && x_o == `CRS_RST_IDX &&
    y_o == `CRS_RST_IDX && pc_o == `CRS_RST_PC && cc_o == `CRS_RST_CC && !prefix_o)
    else $error("state after reset wrong");

  cov_prefixed_write: cover property (
    prefix_i ##[1:4] (prefix_o && instr_end_i && idx_we_i));
  cov_irq_stack: cover property (
    stk_rd_i && (stk_sel_i == crs_pkg::crs_stk_ptrlo) ##1
    stk_rd_i && (stk_sel_i == crs_pkg::crs_stk_ptrhi));
  cov_pop_flags: cover property (stk_wr_cc ##1 instr_end_i);
  cov_bus_read: cover property (wr_i ##1 rd_i ##1 rd_i);

endmodule

// [rtl/crs_index_pair.sv]
// the two index registers and the prefix tracking that picks between them
// assumes the decoder pulses prefix_i once per prefix opcode and instr_end_i once per instruction
`timescale 1ns/1ps
`include "crs_map.svh"

module crs_index_pair (
  // clock and reset
  input logic clk_i,
  input logic reset_i,
  // instruction side
  input logic prefix_i,
  input logic instr_end_i,
  input logic idx_we_i,
  input logic [7:0] idx_wdata_i,
  // first index restore and register port
  input logic x_restore_i,
  input logic [7:0] restore_data_i,
  input logic bus_x_we_i,
  input logic bus_y_we_i,
  input logic [7:0] bus_wdata_i,
  // contents
  output logic [7:0] x_o,
  output logic [7:0] y_o,
  output logic [7:0] sel_o,
  output logic prefix_o
);

  crs_pkg::crs_idx_t mode_r;
  crs_pkg::crs_idx_t mode_nxt;
  logic [7:0] x_r;
  logic [7:0] y_r;

  always_comb begin
    case (mode_r)
      crs_pkg::crs_idx_first: begin
        mode_nxt = prefix_i ? crs_pkg::crs_idx_second : crs_pkg::crs_idx_first;
      end
      crs_pkg::crs_idx_second: begin
        mode_nxt = (instr_end_i && !prefix_i) ? crs_pkg::crs_idx_first : crs_pkg::crs_idx_second;
      end
      default: begin
        mode_nxt = crs_pkg::crs_idx_first;
      end
    endcase
  end

  wire use_y = (mode_r == crs_pkg::crs_idx_second);
  wire ins_wr_x = instr_end_i && idx_we_i && !use_y;
  wire ins_wr_y = instr_end_i && idx_we_i && use_y;
  wire [7:0] x_nxt = x_restore_i ? restore_data_i : ins_wr_x ? idx_wdata_i :
                     bus_x_we_i ? bus_wdata_i : x_r;
  // no restore path into second index
  wire [7:0] y_nxt = ins_wr_y ? idx_wdata_i : bus_y_we_i ? bus_wdata_i : y_r;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_r <= crs_pkg::crs_idx_first;
      x_r <= `CRS_RST_IDX;
      y_r <= `CRS_RST_IDX;
    end else begin
      mode_r <= mode_nxt;
      x_r <= x_nxt;
      y_r <= y_nxt;
    end
  end

  assign x_o = x_r;
  assign y_o = y_r;
  assign sel_o = use_y ? y_r : x_r;
  assign prefix_o = use_y;

endmodule

// [rtl/crs_map.svh]
// constants of the cpu core register set: port addresses, reset values, flag layout
// assumes inclusion by bare name from every design file that needs a figure
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH

// ****************************************
// register port addresses
// ****************************************
`define CRS_A_ACC 3'h0
`define CRS_A_IDX1 3'h1
`define CRS_A_IDX2 3'h2
`define CRS_A_PTRLO 3'h3
`define CRS_A_PTRHI 3'h4
`define CRS_A_CC 3'h5
`define CRS_A_STAT 3'h6

// ****************************************
// reset values
// ****************************************
`define CRS_RST_ACC 8'h00
`define CRS_RST_IDX 8'h00
`define CRS_RST_PC 16'h0000
`define CRS_RST_CC 8'h28
`define CRS_RST_BYTE 8'h00

// ****************************************
// condition flags layout
// ****************************************
`define CRS_CC_C 0
`define CRS_CC_Z 1
`define CRS_CC_N 2
`define CRS_CC_I0 3
`define CRS_CC_H 4
`define CRS_CC_I1 5
`define CRS_CC_USED 8'h3f
`define CRS_ALL8 8'hff

// ****************************************
// pointer step and status layout
// ****************************************
`define CRS_PC_STEP 16'h0001
`define CRS_STAT_PFX 0

`endif

// [rtl/crs_pkg.sv]
// types shared by the cpu core register set files
// assumes nothing beyond a SystemVerilog compiler
package crs_pkg;

  // bytes that the stacking port may move; the second index is absent on purpose
  typedef enum logic [2:0] {
    crs_stk_ptrlo = 3'b000,
    crs_stk_ptrhi = 3'b001,
    crs_stk_acc = 3'b010,
    crs_stk_idx = 3'b011,
    crs_stk_cc = 3'b100
  } crs_stk_t;

  // which index register the current instruction uses
  typedef enum logic {
    crs_idx_first = 1'b0,
    crs_idx_second = 1'b1
  } crs_idx_t;

endpackage

// [rtl/crs_pointer.sv]
// the next-instruction pointer, kept as two separately writable bytes
// assumes load, half writes and increment come from logic on the same clock
`timescale 1ns/1ps
`include "crs_map.svh"

module crs_pointer (
  // clock and reset
  input logic clk_i,
  input logic reset_i,
  // sequencing
  input logic load_i,
  input logic [15:0] target_i,
  input logic inc_i,
  // byte access
  input logic low_we_i,
  input logic high_we_i,
  input logic [7:0] byte_i,
  // contents
  output logic [15:0] pc_o
);

  logic [7:0] low_r;
  logic [7:0] high_r;

  wire [15:0] stepped = {high_r, low_r} + `CRS_PC_STEP;
  // reset value split into its two halves
  wire [15:0] pc_rst = `CRS_RST_PC;
  // load beats byte write beats step
  wire [7:0] low_nxt = load_i ? target_i[7:0] : low_we_i ? byte_i :
                       (inc_i && !high_we_i) ? stepped[7:0] : low_r;
  wire [7:0] high_nxt = load_i ? target_i[15:8] : high_we_i ? byte_i :
                        (inc_i && !low_we_i) ? stepped[15:8] : high_r;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      low_r <= pc_rst[7:0];
      high_r <= pc_rst[15:8];
    end else begin
      low_r <= low_nxt;
      high_r <= high_nxt;
    end
  end

  assign pc_o = {high_r, low_r};

endmodule

// [verif/cpu_core_register_set_test.sv]
// self-checking bench of the core register set with a stacking sequencer model
// assumes crs_core_regs and crs_seq_model compiled before this file
`timescale 1ns/1ps
`include "crs_map.svh"

module cpu_core_register_set_test;
  logic clk_i, reset_i, wr_i, rd_i, instr_end_i, prefix_i, acc_we_i, idx_we_i;
  logic pc_inc_i, pc_load_i, stk_rd_i, stk_we_i, prefix_o, entry, leave, busy;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o, acc_wdata_i, idx_wdata_i, flag_mask_i, flag_val_i;
  logic [7:0] stk_data_i, stk_byte_o, acc_o, x_o, y_o, idx_sel_o, cc_o;
  logic [15:0] pc_target_i, pc_o;
  crs_pkg::crs_stk_t stk_sel_i;
  int error_cnt = 0;
  int n_tests = 0;

  crs_core_regs crs_core_regs_i (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .instr_end_i, .prefix_i, .acc_we_i, .acc_wdata_i, .idx_we_i, .idx_wdata_i,
    .flag_mask_i, .flag_val_i, .pc_inc_i, .pc_load_i, .pc_target_i, .stk_rd_i, .stk_we_i,
    .stk_sel_i, .stk_data_i, .stk_byte_o, .acc_o, .x_o, .y_o, .idx_sel_o, .prefix_o,
    .pc_o, .cc_o);
  crs_seq_model crs_seq_model_i (.clk_i, .reset_i, .entry_i(entry), .exit_i(leave),
    .stk_byte_i(stk_byte_o), .stk_rd_o(stk_rd_i), .stk_we_o(stk_we_i),
    .stk_sel_o(stk_sel_i), .stk_data_o(stk_data_i), .busy_o(busy));

  // ********************************
  // shared tasks
  // ********************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic port_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic port_rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk({8'h00, rdata_o}, {8'h00, exp});
  endtask

  task automatic instr(input logic aw, input logic [7:0] ad, input logic iw,
                       input logic [7:0] id, input logic [7:0] fm, input logic [7:0] fv);
    @(posedge clk_i);
    instr_end_i <= 1'b1;
    acc_we_i <= aw;
    acc_wdata_i <= ad;
    idx_we_i <= iw;
    idx_wdata_i <= id;
    flag_mask_i <= fm;
    flag_val_i <= fv;
    @(posedge clk_i);
    instr_end_i <= 1'b0;
    acc_we_i <= 1'b0;
    idx_we_i <= 1'b0;
    flag_mask_i <= 8'h00;
    #1;
  endtask

  task automatic pulse_pc(input logic ld, input logic [15:0] t);
    @(posedge clk_i);
    pc_load_i <= ld;
    pc_inc_i <= !ld;
    pc_target_i <= t;
    @(posedge clk_i);
    pc_load_i <= 1'b0;
    pc_inc_i <= 1'b0;
    #1;
  endtask

  task automatic model_run(input logic go_in);
    @(posedge clk_i);
    entry <= go_in;
    leave <= !go_in;
    @(posedge clk_i);
    entry <= 1'b0;
    leave <= 1'b0;
    #1;
    for (int k = 0; k < 20 && busy !== 1'b0; k++) @(posedge clk_i);
    #1 chk({15'h0, busy}, 16'h0000);
  endtask

  // ********************************
  // scenarios
  // ********************************
  task automatic s_reset_values();
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, `CRS_RST_CC, 8'h00, 8'h00};
    port_wr(3'h7, 8'ha5);
    for (int i = 0; i < 8; i++) port_rd(i[2:0], rv[i]);
  endtask

  task automatic s_acc_flags();
    @(posedge clk_i);
    acc_we_i <= 1'b1;
    acc_wdata_i <= 8'hc3;
    instr(1'b0, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00);
    chk({8'h00, acc_o}, 16'h0000);
    instr(1'b1, 8'h5a, 1'b0, 8'h00, 8'h0f, 8'hff);
    chk({acc_o, cc_o}, 16'h5a2f);
    instr(1'b0, 8'h00, 1'b0, 8'h00, 8'hff, 8'hff);
    chk({acc_o, cc_o}, {8'h5a, `CRS_CC_USED});
    port_rd(`CRS_A_ACC, 8'h5a);
  endtask

  task automatic s_prefix();
    instr(1'b0, 8'h00, 1'b1, 8'h11, 8'h00, 8'h00);
    chk({x_o, y_o}, 16'h1100);
    @(posedge clk_i);
    prefix_i <= 1'b1;
    @(posedge clk_i);
    prefix_i <= 1'b0;
    #1 chk({idx_sel_o, 7'h0, prefix_o}, 16'h0001);
    port_rd(`CRS_A_STAT, 8'h01);
    instr(1'b0, 8'h00, 1'b1, 8'h22, 8'h00, 8'h00);
    chk({x_o, y_o}, 16'h1122);
    chk({idx_sel_o, 7'h0, prefix_o}, 16'h1100);
  endtask

  task automatic s_pointer();
    pulse_pc(1'b0, 16'h0000);
    chk(pc_o, 16'h0001);
    pulse_pc(1'b1, 16'h00ff);
    pulse_pc(1'b0, 16'h0000);
    chk(pc_o, 16'h0100);
    port_wr(`CRS_A_PTRLO, 8'hab);
    port_wr(`CRS_A_PTRHI, 8'hcd);
    #1 chk(pc_o, 16'hcdab);
    port_rd(`CRS_A_PTRLO, 8'hab);
    port_rd(`CRS_A_PTRHI, 8'hcd);
  endtask

  task automatic s_interrupt();
    model_run(1'b1);
    pulse_pc(1'b1, 16'h1000);
    instr(1'b1, 8'h99, 1'b1, 8'h44, 8'hff, 8'h00);
    chk({x_o, y_o}, 16'h4422);
    model_run(1'b0);
    chk(pc_o, 16'hcdab);
    chk({acc_o, cc_o}, {8'h5a, `CRS_CC_USED});
    chk({x_o, y_o}, 16'h1122);
  endtask

  // port writes to the accumulator, both index registers and the flags, then a reset in mid-run
  task automatic s_port_write();
    port_wr(`CRS_A_ACC, 8'h3c);
    port_wr(`CRS_A_IDX1, 8'h66);
    port_wr(`CRS_A_IDX2, 8'h77);
    port_wr(`CRS_A_CC, 8'hd5);
    port_rd(`CRS_A_ACC, 8'h3c);
    port_rd(`CRS_A_IDX1, 8'h66);
    port_rd(`CRS_A_IDX2, 8'h77);
    port_rd(`CRS_A_CC, 8'hd5 & `CRS_CC_USED);
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    #1 chk({acc_o, cc_o}, {`CRS_RST_ACC, `CRS_RST_CC});
    chk({x_o, y_o}, {`CRS_RST_IDX, `CRS_RST_IDX});
    chk(pc_o, `CRS_RST_PC);
  endtask

  task automatic summarize();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ********************************
  // clock, reset and sequence
  // ********************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    #100000;
    error_cnt++;
    summarize();
  end

  initial begin
    {reset_i, wr_i, rd_i, instr_end_i, prefix_i, acc_we_i, idx_we_i} = 7'h01 << 6;
    {pc_inc_i, pc_load_i, entry, leave} = 4'h0;
    {addr_i, wdata_i, acc_wdata_i, idx_wdata_i, flag_mask_i, flag_val_i} = '0;
    pc_target_i = 16'h0000;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    s_reset_values();
    s_acc_flags();
    s_prefix();
    s_pointer();
    s_interrupt();
    s_port_write();
    summarize();
  end
endmodule

// [verif/crs_seq_model.sv]
// far-side model: interrupt sequencer stacking and unstacking the core bytes
// assumes the core takes stacking strobes on clk_i and answers one cycle later
`timescale 1ns/1ps

module crs_seq_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // commands from the bench
  input wire logic entry_i,
  input wire logic exit_i,
  // stacking port of the core
  input wire logic [7:0] stk_byte_i,
  output logic stk_rd_o,
  output logic stk_we_o,
  output crs_pkg::crs_stk_t stk_sel_o,
  output logic [7:0] stk_data_o,
  output logic busy_o
);
  // ********************************
  // stacking sequence
  // ********************************
  // stacked bytes
  // pointer halves move one at a time; the second index is never stacked
  crs_pkg::crs_stk_t ord [5] = '{crs_pkg::crs_stk_ptrlo, crs_pkg::crs_stk_ptrhi,
    crs_pkg::crs_stk_cc, crs_pkg::crs_stk_acc, crs_pkg::crs_stk_idx};
  logic [7:0] stash [5];

  initial begin
    stk_rd_o = 1'b0;
    stk_we_o = 1'b0;
    stk_sel_o = crs_pkg::crs_stk_ptrlo;
    stk_data_o = 8'h00;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (entry_i && !reset_i) begin
        busy_o <= 1'b1;
        for (int i = 0; i < 6; i++) begin
          stk_rd_o <= (i < 5);
          if (i < 5) begin
            stk_sel_o <= ord[i];
          end
          @(posedge clk_i);
          // byte of the strobe before last is settled now
          if (i > 0) begin
            stash[i - 1] = stk_byte_i;
          end
        end
        busy_o <= 1'b0;
      end else if (exit_i && !reset_i) begin
        busy_o <= 1'b1;
        for (int i = 4; i >= 0; i--) begin
          stk_we_o <= 1'b1;
          stk_sel_o <= ord[i];
          stk_data_o <= stash[i];
          @(posedge clk_i);
        end
        stk_we_o <= 1'b0;
        // released data shows a changed pattern, never the last byte
        stk_data_o <= ~stk_data_o;
        busy_o <= 1'b0;
      end
    end
  end
endmodule
